//--- verilog/shp_pkg.sv
// Constants shared by the host serial slave port
`default_nettype none

package shp_pkg;

    // ------------------------------------------------------------
    // Processor side register locations
    // ------------------------------------------------------------
    localparam logic [7:0]  SFR_CMD_ADDR  = 8'hFD;
    localparam logic [7:0]  SFR_FLAG_ADDR = 8'hF8;
    localparam int          FLAG_BIT      = 7;
    localparam logic [15:0] IO_IRQEN_ADDR = 16'h2701;
    localparam int          IRQEN_BIT     = 7;
    localparam logic [15:0] IO_STAT_ADDR  = 16'h2708;
    localparam logic [15:0] IO_CFG_ADDR   = 16'h270C;
    localparam int          CFG_EN_BIT    = 4;
    localparam int          CFG_SAFE_BIT  = 3;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic        PORT_EN_RST   = 1'b1;
    localparam logic        SAFE_RST      = 1'b0;
    localparam logic        IRQEN_RST     = 1'b0;
    localparam logic        FLAG_RST      = 1'b0;
    localparam logic [5:0]  STAT_HI_RST   = 6'h00;
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [3:0]  PIN_RST       = 4'h8;

    // ------------------------------------------------------------
    // Framing and status layout
    // ------------------------------------------------------------
    localparam logic [15:0] SAFE_LO       = 16'h0400;
    localparam logic [15:0] SAFE_HI       = 16'h040F;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  IDX_ONE       = 3'h1;
    localparam logic [2:0]  IDX_CMD       = 3'h2;
    localparam logic [2:0]  IDX_STAT      = 3'h3;
    localparam logic [2:0]  IDX_DATA      = 3'h4;
    localparam logic [2:0]  CNT_SHORT     = 3'h7;
    localparam int          ST_FLASH      = 1;

    // ------------------------------------------------------------
    // Serial timing
    // ------------------------------------------------------------
    localparam int          MCLK_PS       = 4000;
    localparam int          MIN_BIT_NS    = 100;
    localparam int          MIN_BIT_CYC   =
        (MIN_BIT_NS * 1000 + MCLK_PS - 1) / MCLK_PS;

endpackage : shp_pkg

`default_nettype wire

//--- verilog/shp_sync.sv
// Two-stage synchroniser for pin inputs
`default_nettype none

module shp_sync
    import shp_pkg::*;
#(
    parameter int           W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Pins and synchronised copies
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    if (W < 1)
    begin : g_chk
        $error("shp_sync needs at least one bit");
    end

    // ------------------------------------------------------------
    // One pair of flops per bit
    // ------------------------------------------------------------
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic meta_r;
        logic hold_r;
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                meta_r <= RST_VAL[i];
                hold_r <= RST_VAL[i];
            end
            else
            begin
                meta_r <= d[i];
                hold_r <= meta_r;
            end
        end
        assign q[i] = hold_r;
    end

endmodule : shp_sync

`default_nettype wire

//--- verilog/shp_status.sv
// Builds the latched part of the transaction status byte
`default_nettype none

module shp_status
    import shp_pkg::*;
(
    // Transaction results
    input  wire logic       ready_err,
    input  wire logic       frame_err,
    input  wire logic       rd_par,
    input  wire logic       wr_par,
    input  wire logic       has_data,
    input  wire logic [2:0] total_cnt,
    // Upper six status bits
    output logic      [5:0] stat_hi
);

    wire logic [2:0] data_cnt;

    // Count excludes address, command and status positions
    assign data_cnt = has_data ? 3'(total_cnt - IDX_DATA) : CNT_SHORT;
    assign stat_hi  = {ready_err | frame_err,
                       rd_par,
                       wr_par,
                       data_cnt};

endmodule : shp_status

`default_nettype wire

//--- verilog/shp_port.sv
// Host serial slave port: framing, memory access, status, command
`default_nettype none
// Contract
// - Select high: idle, output floated, inputs ignored
// - Transaction starts on first clock rise
// - Address, command, status, data; or command only
// - Loud multi-byte command loads register, interrupts
// - Single byte always loads command, interrupts
// - Three or more bytes is multi-byte
// - Direction bit set: read, auto-increment; 0x80 quiet
// - Direction bit clear: write, auto-increment; 0x00 quiet
// - Sixteen-bit address reaches data memory only
// - Status byte sent each transaction of four or more bytes, processor readable
// - Status bit 7 flags ready error or partial byte
// - Status bit 6 is sent-data parity
// - Status bit 5 is received-byte parity
// - Status bits 4:2 data count, short gives 111
// - Status bits 1:0 flash mode and ready
// - Error on partial byte, not ready or guarded write
// - Write guard allows only small window
// - Port enable resets to one, clear disables
// - Flag set by hardware, cleared writing zero

module shp_port
    import shp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Serial pins
    input  wire logic        port_select_low,
    input  wire logic        serial_clock_in,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_out_en,
    // Flash mode sense
    input  wire logic        test_pin,
    input  wire logic        flash_program_mode,
    input  wire logic        flash_write_ready,
    // Data memory master
    output logic             mem_req,
    output logic             mem_we,
    output logic      [15:0] mem_addr,
    output logic       [7:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic  [7:0] mem_rdata,
    // Processor register access
    input  wire logic        mpu_wr,
    input  wire logic        mpu_sfr,
    input  wire logic [15:0] mpu_addr,
    input  wire logic  [7:0] mpu_wdata,
    output logic       [7:0] mpu_rdata,
    // Processor side results
    output logic       [7:0] host_command_byte,
    output logic             port_irq,
    output logic             port_pins_enable
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire logic [3:0]  pin_s;
    wire logic        s_csz_n;
    wire logic        s_sck;
    wire logic        s_sdi;
    wire logic        s_test;
    logic             sck_d_r;
    logic             act_d_r;
    logic             port_en_r;
    logic             safe_r;
    logic             irqen_r;
    logic             flag_r;
    logic             irq_r;
    logic      [2:0]  bit_cnt_r;
    logic      [2:0]  idx_r;
    logic      [2:0]  total_r;
    logic      [7:0]  rx_r;
    logic      [7:0]  tx_r;
    logic      [7:0]  cmd_r;
    logic      [7:0]  hcmd_r;
    logic      [7:0]  rdata_r;
    logic      [7:0]  mpu_rdata_r;
    logic      [15:0] addr_r;
    logic      [15:0] mem_addr_r;
    logic      [7:0]  mem_wdata_r;
    logic             mem_req_r;
    logic             mem_we_r;
    logic             sdo_r;
    logic             sdo_oe_r;
    logic             rpar_r;
    logic             wpar_r;
    logic             err_r;
    logic      [5:0]  stat_hi_r;
    wire logic [5:0]  stat_hi_nxt;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    shp_sync #(
        .W       (4),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({port_select_low, serial_clock_in, serial_data_in,
                test_pin}),
        .q    (pin_s)
    );

    assign {s_csz_n, s_sck, s_sdi, s_test} = pin_s;

    wire logic active    = port_en_r & ~s_csz_n;
    wire logic sck_rise  = active & s_sck & ~sck_d_r;
    wire logic sck_fall  = active & ~s_sck & sck_d_r;
    wire logic frame_end = act_d_r & ~active;
    wire logic byte_done = sck_rise & (bit_cnt_r == BIT_LAST);
    wire logic [7:0] byte_val = {rx_r[6:0], s_sdi};

    // ------------------------------------------------------------
    // Decode of framing and memory requests
    // ------------------------------------------------------------
    wire logic dir_rd   = (idx_r == IDX_CMD) ? byte_val[7] : cmd_r[7];
    wire logic busy     = mem_req_r & ~mem_ack;
    wire logic rd_issue = byte_done & (idx_r >= IDX_CMD) & dir_rd;
    wire logic rd_go    = rd_issue & ~busy;
    wire logic tx_rd    = byte_done & (idx_r >= IDX_STAT) & cmd_r[7];
    wire logic wr_byte  = byte_done & (idx_r == IDX_DATA) & ~cmd_r[7];
    wire logic in_win   = (addr_r >= SAFE_LO) & (addr_r <= SAFE_HI);
    wire logic wr_guard = safe_r & ~in_win;
    wire logic wr_go    = wr_byte & ~wr_guard & ~busy;
    wire logic err_set  = ((rd_issue | wr_byte) & busy)
                        | (wr_byte & wr_guard);
    wire logic rd_now   = mem_req_r & mem_ack & ~mem_we_r;
    wire logic [7:0] rd_val = rd_now ? mem_rdata : rdata_r;
    wire logic wpar_take = byte_done & (idx_r != IDX_STAT)
                         & ((idx_r < IDX_STAT) | ~cmd_r[7]);

    // ------------------------------------------------------------
    // Status byte and command register decode
    // ------------------------------------------------------------
    wire logic flash_bit = flash_program_mode & s_test;
    wire logic [7:0] stat_byte = {stat_hi_r, flash_bit,
                                  flash_bit & flash_write_ready};
    wire logic [7:0] tx_nxt = (idx_r == IDX_CMD) ? stat_byte
                            : (tx_rd ? rd_val : 8'h00);
    wire logic cmd_loud = |cmd_r[6:0];
    wire logic single   = idx_r == IDX_ONE;
    wire logic upd_cmd  = frame_end
                        & (single | ((idx_r >= IDX_STAT) & cmd_loud));
    wire logic [7:0] cmd_src = single ? addr_r[15:8] : cmd_r;

    shp_status u_status (
        .ready_err (err_r),
        .frame_err (bit_cnt_r != 3'h0),
        .rd_par    (rpar_r),
        .wr_par    (wpar_r),
        .has_data  (idx_r == IDX_DATA),
        .total_cnt (total_r),
        .stat_hi   (stat_hi_nxt)
    );

    // ------------------------------------------------------------
    // Processor register decode
    // ------------------------------------------------------------
    wire logic sfr_flag = mpu_wr & mpu_sfr & (mpu_addr[7:0] == SFR_FLAG_ADDR);
    wire logic io_wr    = mpu_wr & ~mpu_sfr;
    wire logic cfg_wr   = io_wr & (mpu_addr == IO_CFG_ADDR);
    wire logic irqen_wr = io_wr & (mpu_addr == IO_IRQEN_ADDR);
    wire logic flag_nxt = upd_cmd
                        | (flag_r & ~(sfr_flag & ~mpu_wdata[FLAG_BIT]));
    wire logic irqen_nxt = irqen_wr ? mpu_wdata[IRQEN_BIT] : irqen_r;
    wire logic [7:0] sfr_rd = (mpu_addr[7:0] == SFR_CMD_ADDR) ? hcmd_r
                            : (mpu_addr[7:0] == SFR_FLAG_ADDR)
                              ? {flag_r, 7'h00} : 8'h00;
    wire logic [7:0] io_rd  = (mpu_addr == IO_STAT_ADDR) ? stat_byte
                            : (mpu_addr == IO_IRQEN_ADDR)
                              ? {irqen_r, 7'h00}
                            : (mpu_addr == IO_CFG_ADDR)
                              ? {3'h0, port_en_r, safe_r, 3'h0} : 8'h00;

    // ------------------------------------------------------------
    // Receive side: bit and byte counting
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sck_d_r   <= 1'b0;
            act_d_r   <= 1'b0;
            bit_cnt_r <= 3'h0;
            idx_r     <= 3'h0;
            total_r   <= 3'h0;
            rx_r      <= 8'h00;
        end
        else
        begin
            sck_d_r <= s_sck;
            act_d_r <= active;
            if (!active)
            begin
                bit_cnt_r <= 3'h0;
                idx_r     <= 3'h0;
                total_r   <= 3'h0;
                rx_r      <= 8'h00;
            end
            else if (sck_rise)
            begin
                rx_r      <= byte_val;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (byte_done)
                begin
                    total_r <= total_r + 3'h1;
                    if (idx_r != IDX_DATA)
                        idx_r <= idx_r + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Address, command capture and transaction accumulators
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            addr_r <= 16'h0000;
            cmd_r  <= CMD_RST;
            rpar_r <= 1'b0;
            wpar_r <= 1'b0;
            err_r  <= 1'b0;
        end
        else if (!active)
        begin
            rpar_r <= 1'b0;
            wpar_r <= 1'b0;
            err_r  <= 1'b0;
        end
        else
        begin
            if (byte_done && idx_r == 3'h0)
                addr_r[15:8] <= byte_val;
            else if (byte_done && idx_r == IDX_ONE)
                addr_r[7:0] <= byte_val;
            else if (rd_go || wr_byte)
                addr_r <= addr_r + 16'h0001;
            if (byte_done && idx_r == IDX_CMD)
                cmd_r <= byte_val;
            if (tx_rd)
                rpar_r <= rpar_r ^ (^rd_val);
            if (wpar_take)
                wpar_r <= wpar_r ^ (^byte_val);
            if (err_set)
                err_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter: load at byte end, shift on falling edge
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_r     <= 8'h00;
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else
        begin
            sdo_oe_r <= active;
            if (!active)
            begin
                tx_r  <= 8'h00;
                sdo_r <= 1'b0;
            end
            else if (byte_done)
                tx_r <= tx_nxt;
            else if (sck_fall)
            begin
                sdo_r <= tx_r[7];
                tx_r  <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory master
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= 16'h0000;
            mem_wdata_r <= 8'h00;
            rdata_r     <= 8'h00;
        end
        else
        begin
            if (rd_now)
                rdata_r <= mem_rdata;
            if (rd_go || wr_go)
            begin
                mem_req_r   <= 1'b1;
                mem_we_r    <= wr_go;
                mem_addr_r  <= addr_r;
                mem_wdata_r <= byte_val;
            end
            else if (mem_ack)
                mem_req_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Processor side registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            port_en_r   <= PORT_EN_RST;
            safe_r      <= SAFE_RST;
            irqen_r     <= IRQEN_RST;
            flag_r      <= FLAG_RST;
            irq_r       <= 1'b0;
            hcmd_r      <= CMD_RST;
            stat_hi_r   <= STAT_HI_RST;
            mpu_rdata_r <= 8'h00;
        end
        else
        begin
            if (cfg_wr)
            begin
                port_en_r <= mpu_wdata[CFG_EN_BIT];
                safe_r    <= mpu_wdata[CFG_SAFE_BIT];
            end
            irqen_r     <= irqen_nxt;
            flag_r      <= flag_nxt;
            irq_r       <= flag_nxt & irqen_nxt;
            mpu_rdata_r <= mpu_sfr ? sfr_rd : io_rd;
            if (upd_cmd)
                hcmd_r <= cmd_src;
            if (frame_end)
                stat_hi_r <= stat_hi_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_data_out    = sdo_r;
    assign serial_data_out_en = sdo_oe_r;
    assign mem_req            = mem_req_r;
    assign mem_we             = mem_we_r;
    assign mem_addr           = mem_addr_r;
    assign mem_wdata          = mem_wdata_r;
    assign mpu_rdata          = mpu_rdata_r;
    assign host_command_byte  = hcmd_r;
    assign port_irq           = irq_r;
    assign port_pins_enable   = port_en_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence start_s;
        !active ##1 active;
    endsequence
    sequence single_end_s;
        frame_end && idx_r == IDX_ONE;
    endsequence
    sequence multi_end_s;
        frame_end && idx_r >= IDX_STAT;
    endsequence

    idle_float_a: assert property (!active |=> !sdo_oe_r)
        else $error("output enabled while port idle");
    start_clean_a: assert property (start_s |-> bit_cnt_r == 3'h0
        && idx_r == 3'h0) else $error("frame started with stale count");
    single_cmd_a: assert property (single_end_s |=>
        hcmd_r == $past(addr_r[15:8]) && flag_r)
        else $error("single byte did not load command");
    loud_cmd_a: assert property (multi_end_s ##0 cmd_loud |=>
        hcmd_r == $past(cmd_r) && flag_r)
        else $error("command not loaded at frame end");
    quiet_cmd_a: assert property (multi_end_s ##0 !cmd_loud
        |=> $stable(hcmd_r)) else $error("quiet command changed register");
    guard_win_a: assert property (wr_go |=> mem_we_r
        && (!safe_r || (mem_addr_r >= SAFE_LO && mem_addr_r <= SAFE_HI)))
        else $error("guarded write reached memory");
    short_cnt_a: assert property (frame_end && idx_r != IDX_DATA
        |=> stat_hi_r[2:0] == CNT_SHORT) else $error("short count wrong");
    partial_err_a: assert property (frame_end && bit_cnt_r != 3'h0
        |=> stat_hi_r[5]) else $error("partial byte not flagged");
    flag_hold_a: assert property (flag_r && !sfr_flag |=> flag_r)
        else $error("flag dropped without clear");
    read_incr_a: assert property (rd_go |=> mem_req_r && !mem_we_r
        && addr_r == $past(addr_r) + 16'h0001)
        else $error("read fetch did not advance address");
    flash_zero_a: assert property (!s_test |-> !stat_byte[ST_FLASH])
        else $error("flash bit set with test pin low");

endmodule : shp_port

`default_nettype wire

//--- verification/shp_host_model.sv
// Host side serial master model
`default_nettype none

module shp_host_model
(
    // Pacing clock
    input  wire logic mclk,
    // Serial pins
    output logic      port_select_low,
    output logic      serial_clock_in,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        port_select_low = 1'b1;
        serial_clock_in = 1'b0;
        serial_data_in  = 1'b0;
    end

    task automatic half;
        repeat (20) @(posedge mclk);
        #1;
    endtask : half

    // Sends nb bits from the top of tx; clock idles low
    task automatic frame(input int nb, input logic [63:0] tx,
                         output logic [63:0] rx);
        rx = '0;
        port_select_low = 1'b0;
        half();
        for (int i = 0; i < nb; i++)
        begin
            serial_data_in = tx[63-i];
            half();
            rx = {rx[62:0], serial_data_out};
            serial_clock_in = 1'b1;
            half();
            serial_clock_in = 1'b0;
        end
        half();
        serial_data_in  = ~serial_data_in;
        port_select_low = 1'b1;
        repeat (5) half();
    endtask : frame
endmodule : shp_host_model

`default_nettype wire

//--- verification/shp_port_bench.sv
// Self-checking bench for the host serial slave port
`default_nettype none

`define CHK(a, e) \
    begin \
        checks++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("BAD t=%0t got %h exp %h", $time, a, e); \
        end \
    end

module shp_port_bench
    import shp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0, rst = 1'b1, test_pin = 1'b0, mpu_wr = 1'b0;
    logic        flash_program_mode = 1'b0, flash_write_ready = 1'b0;
    logic        mem_ack = 1'b0, mpu_sfr = 1'b0, ack_nxt;
    logic [15:0] mpu_addr = 16'h0000;
    logic [7:0]  mpu_wdata = 8'h00, mem_rdata = 8'h00;
    logic        port_select_low, serial_clock_in, serial_data_in, oe;
    logic        serial_data_out, mem_req, mem_we, port_irq, port_pins_enable;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, mpu_rdata, cmd, d;
    logic [63:0] rx;
    logic [7:0]  mem [0:4095] = '{default: 8'h00};
    int          checks = 0;
    int          mismatches = 0;

    shp_port uut (.mclk, .rst, .port_select_low, .serial_clock_in,
        .serial_data_in, .serial_data_out, .serial_data_out_en(oe),
        .test_pin, .flash_program_mode, .flash_write_ready, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mpu_wr,
        .mpu_sfr, .mpu_addr, .mpu_wdata, .mpu_rdata,
        .host_command_byte(cmd), .port_irq, .port_pins_enable);
    shp_host_model host (.mclk, .port_select_low, .serial_clock_in,
        .serial_data_in, .serial_data_out);

    always #2 mclk = ~mclk;

    // ----------------------------------------
    // Data memory, answers one cycle later
    // ----------------------------------------
    always @(posedge mclk)
    begin
        ack_nxt = mem_req & ~mem_ack;
        #1;
        mem_ack = ack_nxt;
        if (ack_nxt && mem_we)
            mem[mem_addr[11:0]] = mem_wdata;
        if (ack_nxt)
            mem_rdata = mem[mem_addr[11:0]];
    end

    task automatic wr(input logic s, input logic [15:0] a,
                      input logic [7:0] v);
        mpu_sfr = s;
        mpu_addr = a;
        mpu_wdata = v;
        mpu_wr = 1'b1;
        @(posedge mclk);
        #1;
        mpu_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        mpu_sfr = 1'b0;
        mpu_addr = a;
        @(posedge mclk);
        #1;
        d = mpu_rdata;
    endtask : rd

    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial
    begin
        #100000;
        mismatches++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(port_pins_enable, 1'b1)
        `CHK(oe, 1'b0)
        rd(IO_STAT_ADDR);
        `CHK(d, 8'h00)
        $display("test reset done");
        wr(1'b0, IO_IRQEN_ADDR, 8'h80);
        host.frame(8, {8'h80, 56'h0}, rx);
        `CHK(cmd, 8'h80)
        `CHK(port_irq, 1'b1)
        wr(1'b1, {8'h00, SFR_FLAG_ADDR}, 8'h00);
        `CHK(port_irq, 1'b0)
        $display("test single done");
        host.frame(48, {40'h0010_0000_A5, 8'h3D, 16'h0}, rx);
        `CHK(rx[23:16], 8'h3C)
        `CHK({mem[16], mem[17]}, 16'hA53D)
        `CHK(port_irq, 1'b0)
        $display("test write done");
        host.frame(48, {24'h0010_81, 40'h0}, rx);
        `CHK(rx[23:0], 24'h08A53D)
        `CHK(cmd, 8'h81)
        `CHK(port_irq, 1'b1)
        rd(IO_STAT_ADDR);
        `CHK(d, 8'h68)
        wr(1'b1, {8'h00, SFR_FLAG_ADDR}, 8'h00);
        $display("test read done");
        wr(1'b0, IO_CFG_ADDR, 8'h18);
        host.frame(40, {40'h0020_0000_77, 24'h0}, rx);
        `CHK(mem[32], 8'h00)
        rd(IO_STAT_ADDR);
        `CHK(d, 8'hA4)
        host.frame(40, {40'h0400_0000_5A, 24'h0}, rx);
        `CHK(mem[1024], 8'h5A)
        host.frame(12, {16'hF0F0, 48'h0}, rx);
        rd(IO_STAT_ADDR);
        `CHK(d & 8'h80, 8'h80)
        $display("test guard done");
        wr(1'b0, IO_CFG_ADDR, 8'h00);
        `CHK(port_pins_enable, 1'b0)
        host.frame(8, {8'h55, 56'h0}, rx);
        `CHK(cmd, 8'hF0)
        wr(1'b0, IO_CFG_ADDR, 8'h10);
        test_pin = 1'b1;
        flash_program_mode = 1'b1;
        flash_write_ready = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        rd(IO_STAT_ADDR);
        `CHK(d & 8'h03, 8'h03)
        test_pin = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        rd(IO_STAT_ADDR);
        `CHK(d & 8'h03, 8'h00)
        $display("test enable done");
        results();
    end
endmodule : shp_port_bench

`default_nettype wire
